/* File: src/adc_chan_decode.sv */
// decodes the channel field into multiplexer selections
`timescale 1ns/10ps
module adc_chan_decode (
	input wire logic [4:0] chan_i,
	output logic [3:0] pos_o,
	output logic [3:0] neg_o,
	output logic diff_o,
	output logic gain20_o,
	output logic [2:0] src_o
);

	// single-ended codes first, then the eight differential pairs
	always_comb begin
		pos_o = 4'h0;
		neg_o = 4'h0;
		diff_o = 1'b0;
		gain20_o = 1'b0;
		src_o = adc_ctl_pkg::SRC_PIN;
		if (!chan_i[4]) begin
			if (chan_i <= adc_ctl_pkg::LAST_SINGLE) begin
				pos_o = chan_i[3:0];
			end else begin
				case (chan_i[3:0])
					4'hB: src_o = adc_ctl_pkg::SRC_TEMP;
					4'hC: src_o = adc_ctl_pkg::SRC_BANDGAP;
					4'hD: src_o = adc_ctl_pkg::SRC_SUPPLY_QTR;
					4'hE: src_o = adc_ctl_pkg::SRC_GROUND;
					default: src_o = adc_ctl_pkg::SRC_NONE; // reserved code
				endcase
			end
		end else begin
			diff_o = 1'b1;
			gain20_o = chan_i[0];
			case (chan_i[3:1])
				3'h0: pos_o = 4'h0;
				3'h1: pos_o = 4'h1;
				3'h2: pos_o = 4'h2;
				3'h3: pos_o = 4'h4;
				3'h4: pos_o = 4'h5;
				3'h5: pos_o = 4'h6;
				3'h6: pos_o = 4'h8;
				default: pos_o = 4'h9;
			endcase
			neg_o = pos_o + 4'h1;
		end
	end

endmodule // adc_chan_decode

/* File: src/adc_conversion_control.sv */
// conversion control for the successive-approximation converter
// Behaviour
// - channel codes 0-10 pins, then internal sources
// - top bit set selects pair, odd gain 20x
// - enable on; clearing aborts running conversion
// - single mode per kick; free run continues
// - first conversion after enable takes 25 cycles
// - kick reads one while busy; zero ignored
// - auto trigger starts on selected rising edge
// - flag set when result registers are updated
// - interrupt needs flag, enable and global enable
// - flag cleared by vector or writing one
// - divider field picks 2 up to 128
// - right-justified result, unused bits zero, read-only
// - channel change waits for conversion end
// - reference change deferred, next takes 25 cycles
// - justification change shows immediately
`timescale 1ns/10ps
module adc_conversion_control (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [adc_ctl_pkg::TRIG_W-1:0] trig_i,
	input wire logic global_irq_en_i,
	input wire logic irq_vector_ack_i,
	input wire logic [9:0] core_data_i,
	output logic adc_clk_o,
	output logic core_on_o,
	output logic core_busy_o,
	output logic core_init_o,
	output logic [3:0] pos_sel_o,
	output logic [3:0] neg_sel_o,
	output logic diff_o,
	output logic gain20_o,
	output logic [2:0] src_sel_o,
	output logic [1:0] ref_sel_o,
	output logic conv_irq_o,
	output logic irq_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		adc_ctl_pkg::conv_state_t state;
		logic on;
		logic auto_on;
		logic flag;
		logic ie;
		logic [2:0] div_sel;
		logic [1:0] ref_sel;
		logic left;
		logic [4:0] chan;
		logic [2:0] trig_src;
		logic [4:0] act_chan;
		logic [1:0] act_ref;
		logic need_init;
		logic init_conv;
		logic [4:0] cnt;
		logic [9:0] raw;
		logic [adc_ctl_pkg::TRIG_W-1:0] sync1;
		logic [adc_ctl_pkg::TRIG_W-1:0] sync2;
		logic [adc_ctl_pkg::TRIG_W-1:0] sync3;
		logic [adc_ctl_pkg::TRIG_W-1:0] trig_lvl;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic ack;
		logic [31:0] dat;
		logic irq;
		logic cirq;
		logic [3:0] pos;
		logic [3:0] neg;
		logic diff;
		logic gain20;
		logic [2:0] src;
	} ctl_state_t;

	ctl_state_t r;
	ctl_state_t next_r;

	logic div_tick;
	logic div_clk;
	logic [3:0] dec_pos;
	logic [3:0] dec_neg;
	logic dec_diff;
	logic dec_gain20;
	logic [2:0] dec_src;

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	adc_prescaler u_prescaler (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(next_r.on), // stops with the enable write, not a cycle after it
		.div_sel_i(r.div_sel),
		.adc_clk_o(div_clk),
		.tick_o(div_tick)
	);

	// decode the channel actually in use, not the pending one
	adc_chan_decode u_decode (
		.chan_i(r.act_chan),
		.pos_o(dec_pos),
		.neg_o(dec_neg),
		.diff_o(dec_diff),
		.gain20_o(dec_gain20),
		.src_o(dec_src)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic bus_req;
		logic wr;
		logic wr_ctrl;
		logic wr_chan;
		logic kick_wr;
		logic start;
		logic done;
		logic abort;
		logic [adc_ctl_pkg::TRIG_W-1:0] rise;
		logic trig_edge;
		logic flag_clr;
		logic [1:0] stat_clr;
		logic [1:0] stat_set;
		logic [4:0] len;
		logic [15:0] view;
		bus_req = wb_cyc_i && wb_stb_i && !r.ack;
		wr = bus_req && wb_we_i && wb_sel_i[0];
		wr_ctrl = wr && (wb_adr_i == adc_ctl_pkg::OFS_CTRL);
		wr_chan = wr && (wb_adr_i == adc_ctl_pkg::OFS_CHAN);
		next_r = r;
		start = 1'b0;
		done = 1'b0;
		abort = 1'b0;
		trig_edge = 1'b0;

		// trigger pins: three stages, a level counts once stages two and three agree
		next_r.sync1 = trig_i;
		next_r.sync2 = r.sync1;
		next_r.sync3 = r.sync2;
		rise = r.sync2 & r.sync3 & ~r.trig_lvl;
		next_r.trig_lvl = (r.trig_lvl & (r.sync2 ^ r.sync3)) | (r.sync2 & r.sync3);
		if (r.trig_src != adc_ctl_pkg::TRIG_FREE_RUN) begin
			trig_edge = rise[r.trig_src - 3'h1];
		end

		// register writes
		if (wr_ctrl) begin
			next_r.on = wb_dat_i[adc_ctl_pkg::CTRL_ON];
			next_r.auto_on = wb_dat_i[adc_ctl_pkg::CTRL_AUTO];
			next_r.ie = wb_dat_i[adc_ctl_pkg::CTRL_IE];
			next_r.div_sel = wb_dat_i[adc_ctl_pkg::CTRL_DIV_HI:0];
			if (wb_dat_i[adc_ctl_pkg::CTRL_ON] && !r.on) begin
				next_r.need_init = 1'b1;
			end
		end
		if (wr_chan) begin
			next_r.left = wb_dat_i[adc_ctl_pkg::CHAN_LEFT];
			next_r.chan = wb_dat_i[adc_ctl_pkg::CHAN_SEL_HI:0];
			next_r.ref_sel = wb_dat_i[adc_ctl_pkg::CHAN_REF_HI:adc_ctl_pkg::CHAN_REF_LO];
			if (wb_dat_i[adc_ctl_pkg::CHAN_REF_HI:adc_ctl_pkg::CHAN_REF_LO] != r.ref_sel) begin
				next_r.need_init = 1'b1;
			end
		end
		if (wr && (wb_adr_i == adc_ctl_pkg::OFS_TRIG)) begin
			next_r.trig_src = wb_dat_i[2:0];
		end
		if (wr && (wb_adr_i == adc_ctl_pkg::OFS_IRQ_MASK)) begin
			next_r.irq_mask = wb_dat_i[1:0];
		end

		// writing zero to the kick bit does nothing
		kick_wr = wr_ctrl && wb_dat_i[adc_ctl_pkg::CTRL_KICK];

		// ----------------------------------------------------------------
		// conversion sequencer
		// ----------------------------------------------------------------
		len = r.init_conv ? adc_ctl_pkg::LEN_INIT : adc_ctl_pkg::LEN_NORMAL;
		case (r.state)
			adc_ctl_pkg::ST_IDLE: begin
				// channel and reference follow the register while idle
				next_r.act_chan = next_r.chan;
				next_r.act_ref = next_r.ref_sel;
				if (next_r.on && (kick_wr || (r.auto_on && trig_edge))) begin
					start = 1'b1;
				end
			end
			adc_ctl_pkg::ST_CONVERT: begin
				if (!next_r.on) begin
					abort = 1'b1;
					next_r.state = adc_ctl_pkg::ST_IDLE;
				end else if (div_tick) begin
					if (r.cnt == len - 5'd1) begin
						done = 1'b1;
						next_r.raw = core_data_i;
						next_r.state = adc_ctl_pkg::ST_IDLE;
						next_r.act_chan = next_r.chan;
						next_r.act_ref = next_r.ref_sel;
						// free running restarts at once without software
						if (r.auto_on && r.trig_src == adc_ctl_pkg::TRIG_FREE_RUN) begin
							start = 1'b1;
						end
					end else begin
						next_r.cnt = r.cnt + 5'd1;
					end
				end
			end
			default: begin
				next_r.state = adc_ctl_pkg::ST_IDLE;
			end
		endcase
		if (start) begin
			next_r.state = adc_ctl_pkg::ST_CONVERT;
			next_r.cnt = 5'd0;
			next_r.init_conv = next_r.need_init;
			next_r.need_init = 1'b0;
		end

		// completion flag: a set in the same cycle beats any clear
		flag_clr = r.flag && (irq_vector_ack_i
			|| (wr_ctrl && wb_dat_i[adc_ctl_pkg::CTRL_FLAG]));
		next_r.flag = done || (r.flag && !flag_clr);

		// interrupt status, write one to clear, set wins
		stat_set = {abort, done};
		stat_clr = (wr && (wb_adr_i == adc_ctl_pkg::OFS_IRQ_STAT)) ? wb_dat_i[1:0] : 2'b00;
		next_r.irq_stat = stat_set | (r.irq_stat & ~stat_clr);
		next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
		next_r.cirq = next_r.flag && next_r.ie && global_irq_en_i;

		// multiplexer selections registered from the decoded active channel
		next_r.pos = dec_pos;
		next_r.neg = dec_neg;
		next_r.diff = dec_diff;
		next_r.gain20 = dec_gain20;
		next_r.src = dec_src;

		// result view follows the justify bit with no delay
		view = r.left ? {r.raw, 6'h00} : {6'h00, r.raw};

		// ----------------------------------------------------------------
		// wishbone answer: one wait state, unmapped reads give zero
		// ----------------------------------------------------------------
		next_r.ack = bus_req;
		next_r.dat = 32'h0000_0000;
		if (bus_req && !wb_we_i) begin
			case (wb_adr_i)
				adc_ctl_pkg::OFS_CTRL: begin
					next_r.dat[7:0] = {r.on, r.state == adc_ctl_pkg::ST_CONVERT, r.auto_on,
						r.flag, r.ie, r.div_sel};
				end
				adc_ctl_pkg::OFS_CHAN: begin
					next_r.dat[7:0] = {r.ref_sel, r.left, r.chan};
				end
				adc_ctl_pkg::OFS_RESULT: begin
					next_r.dat[15:0] = view;
				end
				adc_ctl_pkg::OFS_TRIG: begin
					next_r.dat[2:0] = r.trig_src;
				end
				adc_ctl_pkg::OFS_IRQ_STAT: begin
					next_r.dat[1:0] = r.irq_stat;
				end
				adc_ctl_pkg::OFS_IRQ_MASK: begin
					next_r.dat[1:0] = r.irq_mask;
				end
				default: begin
					next_r.dat = 32'h0000_0000;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.state <= adc_ctl_pkg::ST_IDLE;
			r.raw <= adc_ctl_pkg::RESULT_RESET;
			r.chan <= adc_ctl_pkg::CHAN_RESET[4:0];
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// outputs, each straight from a flip-flop
	// ----------------------------------------------------------------
	assign wb_dat_o = r.dat;
	assign wb_ack_o = r.ack;
	assign adc_clk_o = div_clk;
	assign core_on_o = r.on;
	assign core_busy_o = (r.state == adc_ctl_pkg::ST_CONVERT);
	assign core_init_o = r.init_conv;
	assign pos_sel_o = r.pos;
	assign neg_sel_o = r.neg;
	assign diff_o = r.diff;
	assign gain20_o = r.gain20;
	assign src_sel_o = r.src;
	assign ref_sel_o = r.act_ref;
	assign conv_irq_o = r.cirq;
	assign irq_o = r.irq;

endmodule // adc_conversion_control

/* File: src/adc_ctl_pkg.sv */
// shared constants and types for the converter control block
package adc_ctl_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CHAN = 8'h04;
	localparam logic [7:0] OFS_RESULT = 8'h08;
	localparam logic [7:0] OFS_TRIG = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

	// ----------------------------------------------------------------
	// conversion_control_status field positions
	// ----------------------------------------------------------------
	localparam int CTRL_ON = 7;
	localparam int CTRL_KICK = 6;
	localparam int CTRL_AUTO = 5;
	localparam int CTRL_FLAG = 4;
	localparam int CTRL_IE = 3;
	localparam int CTRL_DIV_HI = 2;

	// ----------------------------------------------------------------
	// channel_reference_reg field positions
	// ----------------------------------------------------------------
	localparam int CHAN_REF_HI = 7;
	localparam int CHAN_REF_LO = 6;
	localparam int CHAN_LEFT = 5;
	localparam int CHAN_SEL_HI = 4;

	// ----------------------------------------------------------------
	// interrupt status and mask bits
	// ----------------------------------------------------------------
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ABORT = 1;

	// ----------------------------------------------------------------
	// reset values and timing counts
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CHAN_RESET = 8'h00;
	localparam logic [9:0] RESULT_RESET = 10'h000;
	localparam logic [4:0] LEN_INIT = 5'd25;
	localparam logic [4:0] LEN_NORMAL = 5'd13;
	localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
	localparam int TRIG_W = 7;

	// ----------------------------------------------------------------
	// internal source codes for the multiplexer
	// ----------------------------------------------------------------
	localparam logic [2:0] SRC_PIN = 3'h0;
	localparam logic [2:0] SRC_TEMP = 3'h1;
	localparam logic [2:0] SRC_BANDGAP = 3'h2;
	localparam logic [2:0] SRC_SUPPLY_QTR = 3'h3;
	localparam logic [2:0] SRC_GROUND = 3'h4;
	localparam logic [2:0] SRC_NONE = 3'h7;
	localparam logic [4:0] LAST_SINGLE = 5'h0A;

	typedef enum logic [0:0] {ST_IDLE, ST_CONVERT} conv_state_t;

endpackage

/* File: src/adc_prescaler.sv */
// converter clock divider held in reset while the converter is off
`timescale 1ns/10ps
module adc_prescaler (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic [2:0] div_sel_i,
	output logic adc_clk_o,
	output logic tick_o
);

	typedef struct packed {
		logic [6:0] cnt;
		logic clk;
		logic tick;
	} div_state_t;

	div_state_t r;
	div_state_t next_r;

	// half period minus one; codes 0 and 1 both divide by two
	always_comb begin
		logic [2:0] eff;
		logic [6:0] limit;
		eff = (div_sel_i < 3'h2) ? 3'h1 : div_sel_i;
		limit = (7'h01 << (eff - 3'h1)) - 7'h01;
		next_r = r;
		next_r.tick = 1'b0;
		if (!run_i) begin
			next_r.cnt = 7'h00;
			next_r.clk = 1'b0;
		end else if (r.cnt >= limit) begin
			next_r.cnt = 7'h00;
			next_r.clk = ~r.clk;
			next_r.tick = ~r.clk; // one pulse per converter clock
		end else begin
			next_r.cnt = r.cnt + 7'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign adc_clk_o = r.clk;
	assign tick_o = r.tick;

endmodule // adc_prescaler

/* File: test/adc_core_model.sv */
// behavioural analog multiplexer and converter core
`timescale 1ns/10ps
module adc_core_model (
	input wire logic clk_i,
	input wire logic core_busy_i,
	input wire logic [3:0] pos_sel_i,
	input wire logic diff_i,
	input wire logic gain20_i,
	input wire logic [2:0] src_sel_i,
	output logic [9:0] core_data_o
);
	logic [9:0] held = 10'h000;
	logic [9:0] live;
	// sample follows the routed input so a wrong selection shows in the result
	assign live = {1'b1, diff_i ? 3'h0 : src_sel_i, gain20_i, diff_i,
		(diff_i || src_sel_i == adc_ctl_pkg::SRC_PIN) ? pos_sel_i : 4'hA};
	// outside a conversion the core output is not valid: show the inverse
	always_ff @(posedge clk_i) begin
		if (core_busy_i) begin
			held <= live;
		end
	end
	assign core_data_o = core_busy_i ? live : ~held;
endmodule // adc_core_model

/* File: test/adc_ctl_chk.sv */
// port-level checks for the converter control block
`timescale 1ns/10ps
module adc_ctl_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic global_irq_en_i,
	input wire logic adc_clk_o,
	input wire logic core_on_o,
	input wire logic core_busy_o,
	input wire logic core_init_o,
	input wire logic conv_irq_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic prev_clk;
	logic [5:0] ticks;
	logic ctl_wr;
	// converter clock rises within the running conversion
	always_ff @(posedge clk_i) begin
		prev_clk <= adc_clk_o;
		if (rst_i || !core_busy_o) begin
			ticks <= 6'h00;
		end else if (adc_clk_o && !prev_clk && ticks != 6'h3F) begin
			ticks <= ticks + 6'h01;
		end
	end
	// control write offered and not yet answered
	assign ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
		&& wb_adr_i == adc_ctl_pkg::OFS_CTRL;
	chk_ack_timely: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer late or too long");
	chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data not zero outside ack");
	chk_irq_global: assert property (conv_irq_o |-> $past(global_irq_en_i))
		else $error("interrupt without global enable");
	chk_clk_held: assert property (!core_on_o |-> !adc_clk_o)
		else $error("converter clock runs while off");
	chk_off_idle: assert property (!core_on_o [*2] |-> !core_busy_o)
		else $error("busy while converter off");
	chk_kick_start: assert property (ctl_wr && wb_dat_i[7:6] == 2'h3 && !core_busy_o
		|-> ##[1:2] core_busy_o)
		else $error("kick did not start a conversion");
	chk_off_abort: assert property (ctl_wr && !wb_dat_i[7] |-> ##[1:2] (!core_busy_o && !core_on_o))
		else $error("switch off did not abort");
	// tolerance of one tick either way covers where the count is sampled
	chk_conv_len: assert property ($fell(core_busy_o) && core_on_o
		|-> (core_init_o ? (ticks >= 6'h18 && ticks <= 6'h1A)
		: (ticks >= 6'h0C && ticks <= 6'h0E)))
		else $error("conversion length wrong");
endmodule // adc_ctl_chk
bind adc_conversion_control adc_ctl_chk chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .global_irq_en_i, .adc_clk_o,
	.core_on_o, .core_busy_o, .core_init_o, .conv_irq_o);

/* File: test/testbench.sv */
// self-checking bench for the converter control block
`timescale 1ns/10ps
module testbench;
	typedef struct packed {
		logic [2:0] dsel;
		logic [7:0] dfac;
		logic [3:0] ppos;
	} row_t;
	row_t rows [8] = '{'{3'h0, 8'h02, 4'h0}, '{3'h1, 8'h02, 4'h1}, '{3'h2, 8'h04, 4'h2},
		'{3'h3, 8'h08, 4'h4}, '{3'h4, 8'h10, 4'h5}, '{3'h5, 8'h20, 4'h6},
		'{3'h6, 8'h40, 4'h8}, '{3'h7, 8'h80, 4'h9}};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic [6:0] trig_i = 7'h00;
	logic global_irq_en_i = 1'b0, irq_vector_ack_i = 1'b0;
	logic [9:0] core_data_i, raw;
	logic wb_ack_o, adc_clk_o, core_on_o, core_busy_o, core_init_o, diff_o, gain20_o;
	logic conv_irq_o, irq_o, d;
	logic [3:0] pos_sel_o, neg_sel_o, ep;
	logic [2:0] src_sel_o, es;
	logic [1:0] ref_sel_o;
	logic [4:0] c;
	logic [7:0] dv;
	time t0;
	int err_count = 0;
	int n_tests = 0;
	always #12.5 clk_i = ~clk_i;
	adc_conversion_control uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .trig_i, .global_irq_en_i,
		.irq_vector_ack_i, .core_data_i, .adc_clk_o, .core_on_o, .core_busy_o, .core_init_o,
		.pos_sel_o, .neg_sel_o, .diff_o, .gain20_o, .src_sel_o, .ref_sel_o, .conv_irq_o, .irq_o);
	adc_core_model core (.clk_i, .core_busy_i(core_busy_o), .pos_sel_i(pos_sel_o),
		.diff_i(diff_o), .gain20_i(gain20_o), .src_sel_i(src_sel_o), .core_data_o(core_data_i));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// whole-word single cycle; software never read-modify-writes the control word
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= wd;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		if (n >= 20) begin
			err_count++;
			finish_test();
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(q, e);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (core_busy_o !== 1'b0 && n < 9000);
		if (n >= 9000) begin
			err_count++;
			finish_test();
		end
		repeat (2) @(posedge clk_i);
	endtask
	task automatic finish_test();
		if (err_count == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// hang guard, well above the expected run time
	initial begin
		#2000000;
		err_count++;
		finish_test();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
		for (int a = 0; a < 8; a++) rchk(8'(a * 4), 32'h0);
		// each row: one divider with codes r and r+8 (pin, internal source or reserved) and one pair at both gains
		for (int r = 0; r < 8; r++) begin
			for (int k = 0; k < 4; k++) begin
				c = (k == 0) ? 5'(r) : (k == 1) ? 5'(r + 8) : 5'(14 + 2 * r + k);
				d = c[4];
				es = (c <= 5'h0A) ? adc_ctl_pkg::SRC_PIN
					: (c == 5'h0F) ? adc_ctl_pkg::SRC_NONE : 3'(c - 5'h0A);
				ep = d ? rows[r].ppos : c[3:0];
				raw = {1'b1, d ? 3'h0 : es, d && c[0], d, (d || es == 3'h0) ? ep : 4'hA};
				dv = {5'h11, rows[r].dsel};
				global_irq_en_i <= k[0];
				bus(1'b1, adc_ctl_pkg::OFS_CHAN, {27'h0, c});
				bus(1'b1, adc_ctl_pkg::OFS_CTRL, {24'h0, dv | 8'h40});
				rchk(adc_ctl_pkg::OFS_CTRL, {24'h0, dv | 8'h40});
				wait_idle();
				rchk(adc_ctl_pkg::OFS_CTRL, {24'h0, dv | 8'h10});
				check(conv_irq_o, k[0]);
				rchk(adc_ctl_pkg::OFS_RESULT, {22'h0, raw});
				if (!d) check(src_sel_o, es);
				if (d || es == 3'h0) check(pos_sel_o, ep);
				if (d) check(neg_sel_o, ep + 4'h1);
				check({diff_o, gain20_o}, {d, d && c[0]});
				bus(1'b1, adc_ctl_pkg::OFS_CTRL, {24'h0, dv});
				check(conv_irq_o, k[0]);
				if (k[0]) begin
					irq_vector_ack_i <= 1'b1;
					@(posedge clk_i);
					irq_vector_ack_i <= 1'b0;
				end else begin
					bus(1'b1, adc_ctl_pkg::OFS_CTRL, {24'h0, dv | 8'h10});
				end
				rchk(adc_ctl_pkg::OFS_CTRL, {24'h0, dv});
				if (k == 0) begin
					@(posedge adc_clk_o);
					t0 = $time;
					@(posedge adc_clk_o);
					check(32'(($time - t0) / 25), {24'h0, rows[r].dfac});
				end
			end
		end
		// justification switches the view of the stored result at once
		bus(1'b1, adc_ctl_pkg::OFS_CHAN, 32'h3F);
		rchk(adc_ctl_pkg::OFS_RESULT, {16'h0, raw, 6'h00});
		bus(1'b1, adc_ctl_pkg::OFS_CHAN, 32'h1F);
		// switching off mid-conversion: no flag, abort event raised
		bus(1'b1, adc_ctl_pkg::OFS_IRQ_STAT, 32'h3);
		bus(1'b1, adc_ctl_pkg::OFS_IRQ_MASK, 32'h3);
		bus(1'b1, adc_ctl_pkg::OFS_CTRL, 32'hC7);
		repeat (20) @(posedge clk_i);
		bus(1'b1, adc_ctl_pkg::OFS_CTRL, 32'h07);
		rchk(adc_ctl_pkg::OFS_CTRL, 32'h07);
		rchk(adc_ctl_pkg::OFS_IRQ_STAT, 32'h2);
		check(irq_o, 1'b1);
		bus(1'b1, adc_ctl_pkg::OFS_IRQ_STAT, 32'h2);
		rchk(adc_ctl_pkg::OFS_IRQ_STAT, 32'h0);
		check(irq_o, 1'b0);
		// free running keeps converting after a single kick
		bus(1'b1, adc_ctl_pkg::OFS_CTRL, 32'hE0);
		repeat (120) @(posedge clk_i);
		check(core_busy_o, 1'b1);
		rchk(adc_ctl_pkg::OFS_CTRL, 32'hF0);
		bus(1'b1, adc_ctl_pkg::OFS_CTRL, 32'h10);
		// trigger edge starts; channel and reference wait for completion
		bus(1'b1, adc_ctl_pkg::OFS_TRIG, 32'h1);
		bus(1'b1, adc_ctl_pkg::OFS_CTRL, 32'hA0);
		repeat (10) @(posedge clk_i);
		check(core_busy_o, 1'b0);
		trig_i <= 7'h01;
		repeat (8) @(posedge clk_i);
		check(core_busy_o, 1'b1);
		bus(1'b1, adc_ctl_pkg::OFS_CHAN, 32'h43);
		check({ref_sel_o, pos_sel_o}, {2'h0, 4'h9});
		wait_idle();
		check({ref_sel_o, pos_sel_o}, {2'h1, 4'h3});
		trig_i <= 7'h00;
		repeat (5) @(posedge clk_i);
		trig_i <= 7'h01;
		repeat (8) @(posedge clk_i);
		check({core_busy_o, core_init_o}, 2'h3);
		wait_idle();
		// reset in mid-conversion returns registers and outputs to zero
		bus(1'b1, adc_ctl_pkg::OFS_CTRL, 32'hC0);
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		check({core_busy_o, core_on_o, adc_clk_o, conv_irq_o, irq_o}, 32'h0);
		rchk(adc_ctl_pkg::OFS_CTRL, 32'h0);
		rchk(adc_ctl_pkg::OFS_RESULT, 32'h0);
		rchk(adc_ctl_pkg::OFS_CHAN, 32'h0);
		finish_test();
	end
endmodule // testbench
